// [port_group_pkg.sv]
/*
  port_group_pkg: offsets, reset values and field layout for the parallel port group.
  Assumes a byte-wide register port with one-cycle read latency on clk_sys.
*/
// Notes on behaviour
// - direction bit 0 input, 1 output; write-only; port A bit7 resets by mode.
// - port 4 pull-up acts only while that pin's direction bit is 0.
// - port 7 read returns current levels of its eight pins, nothing stored.
// - port 9 data has bits 5..0 writable, reset 0, read back from the pins; bits 7,6 read 1.
// - port B data is eight read/write bits cleared at reset, driving output pins.
package port_group_pkg;
  localparam int           PORT_W          = 8;
  localparam int           ADDR_W          = 8;
  localparam logic [7:0]   OFF_PORT4_DIR   = 8'hC5;
  localparam logic [7:0]   OFF_PORT4_DATA  = 8'hC7;
  localparam logic [7:0]   OFF_PORT6_DATA  = 8'hCB;
  localparam logic [7:0]   OFF_PORT7_PINS  = 8'hCE;
  localparam logic [7:0]   OFF_PORT8_DATA  = 8'hCF;
  localparam logic [7:0]   OFF_PORTA_DIR   = 8'hD1;
  localparam logic [7:0]   OFF_PORT9_DATA  = 8'hD2;
  localparam logic [7:0]   OFF_PORTA_DATA  = 8'hD3;
  localparam logic [7:0]   OFF_PORTB_DIR   = 8'hD4;
  localparam logic [7:0]   OFF_PORTB_DATA  = 8'hD6;
  localparam logic [7:0]   OFF_PORT4_PULL  = 8'hDA;
  localparam logic [7:0]   RST_DATA        = 8'h00;
  localparam logic [7:0]   RST_DIR         = 8'h00;
  localparam logic [7:0]   RST_PULL        = 8'h00;
  localparam logic [7:0]   PORT9_MASK      = 8'h3F;
  localparam logic [7:0]   PORT9_FILL      = 8'hC0;
  localparam int           PORTA_MSB       = 7;
endpackage : port_group_pkg

// [pin_bus_if.sv]
/*
  pin_bus_if: carries one bidirectional port's pin signals between modules.
  Assumes one clock domain; pin levels here are already synchronised.
*/
`timescale 1ns/1ps
interface pin_bus_if #(parameter int W = 8);
  logic [W-1:0] dir;
  logic [W-1:0] data;
  logic [W-1:0] pinLevel;
  logic [W-1:0] readBack;
  modport ctl (output dir, output data, input readBack);
  modport pin (input dir, input data, input pinLevel, output readBack);
endinterface : pin_bus_if

// [port_readback.sv]
/*
  port_readback: per-bit read view of one port: stored data on outputs, pin on inputs.
  Assumes pinLevel is already synchronised to clk_sys.
*/
`timescale 1ns/1ps
module port_readback
#(
  parameter int W = 8
)
(
  // pin view
  pin_bus_if.pin bus
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      assign bus.readBack[i] = bus.dir[i] ? bus.data[i] : bus.pinLevel[i];
    end
  endgenerate
endmodule : port_readback

// [parallel_port_group.sv]
/*
  parallel_port_group: byte-wide ports 4,6,7,8,9,A,B; direction control on ports 4, A and B, pull-up control on port 4.
  Assumes a one-cycle register port on clk_sys; pins come from outside and are
  synchronised by three flops, a change accepted once stages two and three agree.
*/
// Chosen here: strobed register access.
`timescale 1ns/1ps
module parallel_port_group
  import port_group_pkg::*;
#(
  parameter int NPORT = 6
)
(
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // mode strap: high when operating in mode 1 or 2
  input  wire logic                        modeExpanded,
  // register port
  input  wire logic [port_group_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [port_group_pkg::PORT_W-1:0] regWrData,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic [port_group_pkg::PORT_W-1:0] regRdData,
  // pins of ports 4,6,8,9,A,B (index order): levels in, drive and enables out
  input  wire logic [NPORT*8-1:0]          pinIn,
  output logic [NPORT*8-1:0]               pinOut,
  output logic [NPORT*8-1:0]               pinOe,
  // port 4 pull-up enables
  output logic [port_group_pkg::PORT_W-1:0] port4Pullup,
  // port 7 input-only pins
  input  wire logic [port_group_pkg::PORT_W-1:0] port7Pins
);
  import port_group_pkg::*;

  // port index order inside pinIn, pinOut and pinOe
  localparam int P4 = 0;
  localparam int P6 = 1;
  localparam int P8 = 2;
  localparam int P9 = 3;
  localparam int PA = 4;
  localparam int PB = 5;
  localparam int NW = NPORT * 8 + 8;

  logic [7:0]    dirReg   [NPORT];
  logic [7:0]    dataReg  [NPORT];
  logic [7:0]    next_dirReg  [NPORT];
  logic [7:0]    next_dataReg [NPORT];
  logic [7:0]    pullReg;
  logic [7:0]    next_pullReg;
  logic [7:0]    readBack [NPORT];
  logic [NW-1:0] sync1;
  logic [NW-1:0] sync2;
  logic [NW-1:0] sync3;
  logic [NW-1:0] stable;
  logic [NW-1:0] next_stable;
  logic [7:0]    next_rdData;
  logic          strapTaken;
  logic          next_strapTaken;
  logic [NPORT*8-1:0] next_pinOut;
  logic [NPORT*8-1:0] next_pinOe;
  logic [7:0]    next_port4Pullup;

  // three-stage sync; stable moves only when stages two and three agree
  // the agreement stage costs a cycle of latency but rejects a one-cycle glitch
  always_comb
  begin
    for (int k = 0; k < NW; k++)
      next_stable[k] = (sync2[k] == sync3[k]) ? sync3[k] : stable[k];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync1  <= '0;
      sync2  <= '0;
      sync3  <= '0;
      stable <= '0;
    end
    else
    begin
      sync1  <= {port7Pins, pinIn};
      sync2  <= sync1;
      sync3  <= sync2;
      stable <= next_stable;
    end
  end

  // each port's read view mixes stored bits and pin bits according to direction
  genvar g;
  generate
    for (g = 0; g < NPORT; g++)
    begin : g_port
      pin_bus_if #(.W(8)) pb ();
      assign pb.dir      = dirReg[g];
      assign pb.data     = dataReg[g];
      assign pb.pinLevel = stable[g*8 +: 8];
      assign readBack[g] = pb.readBack;
      port_readback #(.W(8)) u_rb
      (
        .bus (pb)
      );
    end
  endgenerate

  // register writes; strap for port A bit 7 taken once after reset release
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      next_dirReg[p]  = dirReg[p];
      next_dataReg[p] = dataReg[p];
    end
    next_pullReg    = pullReg;
    next_strapTaken = 1'b1;
    // the strap is static around reset release, so it is taken without synchronisers
    if (!strapTaken)
      next_dirReg[PA][PORTA_MSB] = ~modeExpanded;
    if (regWr)
    begin
      if (regAddr == OFF_PORT4_DIR)
        next_dirReg[P4] = regWrData;
      else if (regAddr == OFF_PORTA_DIR)
        next_dirReg[PA] = regWrData;
      else if (regAddr == OFF_PORTB_DIR)
        next_dirReg[PB] = regWrData;
      else if (regAddr == OFF_PORT4_DATA)
        next_dataReg[P4] = regWrData;
      else if (regAddr == OFF_PORT6_DATA)
        next_dataReg[P6] = regWrData;
      else if (regAddr == OFF_PORT8_DATA)
        next_dataReg[P8] = regWrData;
      else if (regAddr == OFF_PORT9_DATA)
        next_dataReg[P9] = regWrData & PORT9_MASK;
      else if (regAddr == OFF_PORTA_DATA)
        next_dataReg[PA] = regWrData;
      else if (regAddr == OFF_PORTB_DATA)
        next_dataReg[PB] = regWrData;
      else if (regAddr == OFF_PORT4_PULL)
        next_pullReg = regWrData;
    end
  end

  // direction registers are write-only and read back as ones
  // idle cycles return zero so a stale answer never lingers on regRdData
  always_comb
  begin
    next_rdData = 8'h00;
    if (regRd)
    begin
      if (regAddr == OFF_PORT7_PINS)
        next_rdData = stable[NPORT*8 +: 8];
      else if (regAddr == OFF_PORT4_DATA)
        next_rdData = readBack[P4];
      else if (regAddr == OFF_PORT6_DATA)
        next_rdData = readBack[P6];
      else if (regAddr == OFF_PORT8_DATA)
        next_rdData = readBack[P8];
      else if (regAddr == OFF_PORT9_DATA)
        next_rdData = (readBack[P9] & PORT9_MASK) | PORT9_FILL;
      else if (regAddr == OFF_PORTA_DATA)
        next_rdData = readBack[PA];
      else if (regAddr == OFF_PORTB_DATA)
        next_rdData = readBack[PB];
      else if (regAddr == OFF_PORT4_PULL)
        next_rdData = pullReg;
      else if (regAddr == OFF_PORT4_DIR || regAddr == OFF_PORTA_DIR
               || regAddr == OFF_PORTB_DIR)
        next_rdData = 8'hFF;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        dirReg[p]  <= RST_DIR;
        dataReg[p] <= RST_DATA;
      end
      pullReg     <= RST_PULL;
      strapTaken  <= 1'b0;
    end
    else
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        dirReg[p]  <= next_dirReg[p];
        dataReg[p] <= next_dataReg[p];
      end
      pullReg     <= next_pullReg;
      strapTaken  <= next_strapTaken;
    end
  end

  // pin drive follows the values being loaded, so pins move on the write edge itself
  always_comb
  begin
    next_pinOut = '0;
    next_pinOe  = '0;
    for (int p = 0; p < NPORT; p++)
    begin
      next_pinOut[p*8 +: 8] = next_dataReg[p];
      next_pinOe[p*8 +: 8]  = next_dirReg[p];
    end
    next_port4Pullup = next_pullReg & ~next_dirReg[P4];
  end

  // every top-level output comes straight from this stage
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pinOut      <= '0;
      pinOe       <= '0;
      port4Pullup <= '0;
      regRdData   <= '0;
    end
    else
    begin
      pinOut      <= next_pinOut;
      pinOe       <= next_pinOe;
      port4Pullup <= next_port4Pullup;
      regRdData   <= next_rdData;
    end
  end
endmodule : parallel_port_group

// [parallel_port_group_props.sv]
/* parallel_port_group_props: port assertions for the port group.
   Assumes bind onto parallel_port_group; read data one cycle after regRd. */
`timescale 1ns/1ps
module parallel_port_group_props
  import port_group_pkg::*;
#(
  parameter int NPORT = 6
)
(
  // clock and reset
  input wire logic                                clk_sys,
  input wire logic                                rst,
  // register port
  input wire logic [port_group_pkg::ADDR_W-1:0]   regAddr,
  input wire logic [port_group_pkg::PORT_W-1:0]   regWrData,
  input wire logic                                regWr,
  input wire logic                                regRd,
  input wire logic [port_group_pkg::PORT_W-1:0]   regRdData,
  // pins
  input wire logic [NPORT*8-1:0]                  pinOut,
  input wire logic [NPORT*8-1:0]                  pinOe,
  input wire logic [port_group_pkg::PORT_W-1:0]   port4Pullup,
  input wire logic [port_group_pkg::PORT_W-1:0]   port7Pins
);
  import port_group_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_dir_sets_oe: assert property (regWr && regAddr == OFF_PORTB_DIR |=>
    pinOe[47:40] == $past(regWrData)) else $error("direction write not on enables");
  a_dir_reads_ff: assert property (regRd && regAddr == OFF_PORTB_DIR |=>
    regRdData == 8'hFF) else $error("direction read not all ones");
  a_pullup_inputs: assert property ((port4Pullup & pinOe[7:0]) == 8'h00)
    else $error("pull-up on a driven pin");
  a_port7_levels: assert property (($stable(port7Pins) [*6] ##0
    regRd && regAddr == OFF_PORT7_PINS) |=> regRdData == $past(port7Pins))
    else $error("port 7 read differs from pins");
  a_port9_top: assert property (regRd && regAddr == OFF_PORT9_DATA |=>
    regRdData[7:6] == 2'h3) else $error("port 9 top bits not one");
  a_data_drives: assert property (regWr && regAddr == OFF_PORTB_DATA |=>
    pinOut[47:40] == $past(regWrData)) else $error("port B drive wrong");
  a_out_readback: assert property (regRd && regAddr == OFF_PORTB_DATA
    && pinOe[47:40] == 8'hFF |=> regRdData == pinOut[47:40])
    else $error("output readback wrong");
endmodule : parallel_port_group_props
bind parallel_port_group parallel_port_group_props #(.NPORT(NPORT)) u_props
(
  .clk_sys     (clk_sys),
  .rst         (rst),
  .regAddr     (regAddr),
  .regWrData   (regWrData),
  .regWr       (regWr),
  .regRd       (regRd),
  .regRdData   (regRdData),
  .pinOut      (pinOut),
  .pinOe       (pinOe),
  .port4Pullup (port4Pullup),
  .port7Pins   (port7Pins)
);

// [pin_model.sv]
/* pin_model: the outside world on the port pins.
   Assumes a released pin shows extLevel unless a port 4 pull-up lifts it. */
`timescale 1ns/1ps
module pin_model
(
  // design side
  input  wire logic [47:0] pinOut,
  input  wire logic [47:0] pinOe,
  input  wire logic [7:0]  port4Pullup,
  // levels offered on undriven pins
  input  wire logic [47:0] extLevel,
  output logic [47:0]      pinIn
);
  always_comb
  begin
    pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
    pinIn[7:0] = pinIn[7:0] | (~pinOe[7:0] & port4Pullup);
  end
endmodule : pin_model

// [testbench.sv]
/* testbench: register-level tests of parallel_port_group with a pin model.
   Assumes the package offsets and one-cycle read answer. */
`timescale 1ns/1ps
module testbench;
  import port_group_pkg::*;
  logic        clk_sys, rst, modeExpanded, regWr, regRd;
  logic [7:0]  regAddr, regWrData, regRdData, port4Pullup, port7Pins, v;
  logic [47:0] pinIn, pinOut, pinOe, extLevel;
  int          err_count, n_compared;
  parallel_port_group #(.NPORT(6)) DUT (.clk_sys(clk_sys), .rst(rst),
    .modeExpanded(modeExpanded), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .port4Pullup(port4Pullup), .port7Pins(port7Pins));
  pin_model PARTNER (.pinOut(pinOut), .pinOe(pinOe), .port4Pullup(port4Pullup),
    .extLevel(extLevel), .pinIn(pinIn));
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one quiet edge after the strobe, so outputs have settled when the caller looks
  task automatic wr(logic [7:0] a, logic [7:0] d);
    regWr <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'h0;
    @(posedge clk_sys);
  endtask : wr
  // caller sits just after an edge; v is taken in the single answer cycle
  task automatic rd(logic [7:0] a);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'h0;
    @(posedge clk_sys);
    v = regRdData;
  endtask : rd
  task automatic do_reset(logic m);
    rst <= 1'h1;
    modeExpanded <= m;
    repeat (10) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (3) @(posedge clk_sys);
  endtask : do_reset
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial
  begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #(3000 * 25);
    err_count++;
    finish_test;
  end
  initial
  begin
    {regWr, regRd, regAddr, regWrData} <= '0;
    extLevel <= 48'h3C0000C30000;
    port7Pins <= 8'h96;
    do_reset(1'h1);
    chk("porta oe mode12", pinOe[39:32], 8'h00);
    do_reset(1'h0);
    chk("porta oe other", pinOe[39:32], 8'h80);
    $display("test reset done");
    rd(OFF_PORT9_DATA);
    chk("port9 reset", v, 8'hC0);
    wr(OFF_PORT9_DATA, 8'hFF);
    chk("port9 drive", pinOut[31:24], 8'h3F);
    rd(OFF_PORT9_DATA);
    chk("port9 top", {v[7:6], 6'h00}, 8'hC0);
    wr(OFF_PORTB_DIR, 8'hFF);
    wr(OFF_PORTB_DATA, 8'hA5);
    chk("portb out", pinOut[47:40], 8'hA5);
    chk("portb oe", pinOe[47:40], 8'hFF);
    rd(OFF_PORTB_DATA);
    chk("portb read", v, 8'hA5);
    rd(OFF_PORTB_DIR);
    chk("portb dir read", v, 8'hFF);
    wr(OFF_PORTB_DIR, 8'h0F);
    repeat (6) @(posedge clk_sys);
    rd(OFF_PORTB_DATA);
    chk("portb mixed", v, 8'h35);
    $display("test port9 and port B done");
    rd(OFF_PORT7_PINS);
    chk("port7 a", v, 8'h96);
    port7Pins <= 8'h69;
    repeat (6) @(posedge clk_sys);
    rd(OFF_PORT7_PINS);
    chk("port7 b", v, 8'h69);
    wr(OFF_PORT4_DIR, 8'h0F);
    wr(OFF_PORT4_PULL, 8'hFF);
    chk("port4 pullup", port4Pullup, 8'hF0);
    repeat (6) @(posedge clk_sys);
    rd(OFF_PORT4_DATA);
    chk("port4 read", v, 8'hF0);
    rd(8'h00);
    chk("unmapped", v, 8'h00);
    $display("test port7 and port4 done");
    wr(OFF_PORTA_DIR, 8'h0F);
    wr(OFF_PORTA_DATA, 8'h5A);
    chk("porta oe", pinOe[39:32], 8'h0F);
    chk("porta out", pinOut[39:32], 8'h5A);
    repeat (6) @(posedge clk_sys);
    rd(OFF_PORTA_DATA);
    chk("porta read", v, 8'h0A);
    wr(OFF_PORT6_DATA, 8'h77);
    chk("port6 out", pinOut[15:8], 8'h77);
    chk("port6 oe", pinOe[15:8], 8'h00);
    rd(OFF_PORT8_DATA);
    chk("port8 read", v, 8'hC3);
    $display("test port A, 6 and 8 done");
    finish_test;
  end
endmodule : testbench
